// [sps_pkg.sv]
// Shared constants and types of the stepper motion parameter set
package sps_pkg;

  // Register addresses on the command port
  localparam logic [5:0] ADDR_DECEL  = 6'h05;
  localparam logic [5:0] ADDR_MAXSPD = 6'h07;
  localparam logic [5:0] ADDR_MINSPD = 6'h08;
  localparam logic [5:0] ADDR_HOLD   = 6'h09;
  localparam logic [5:0] ADDR_RUN    = 6'h0a;
  localparam logic [5:0] ADDR_ACCAMP = 6'h0b;
  localparam logic [5:0] ADDR_DECAMP = 6'h0c;
  localparam logic [5:0] ADDR_INTSPD = 6'h0d;
  localparam logic [5:0] ADDR_STSLP  = 6'h0e;
  localparam logic [5:0] ADDR_FNACC  = 6'h0f;
  localparam logic [5:0] ADDR_FNDEC  = 6'h10;
  localparam logic [5:0] ADDR_THERM  = 6'h11;
  localparam logic [5:0] ADDR_ADC    = 6'h12;
  localparam logic [5:0] ADDR_OCD    = 6'h13;
  localparam logic [5:0] ADDR_STALL  = 6'h14;
  localparam logic [5:0] ADDR_FSSPD  = 6'h15;
  localparam logic [5:0] ADDR_STEP   = 6'h16;

  // Field positions
  localparam int MINSPD_LSPD_BIT = 12;
  localparam int STEP_SYNC_EN    = 7;
  localparam int STEP_SYNC_LSB   = 4;

  // Reset values
  localparam logic [11:0] RST_DECEL  = 12'h000;
  localparam logic [9:0]  RST_MAXSPD = 10'h000;
  localparam logic [12:0] RST_MINSPD = 13'h0000;
  localparam logic [9:0]  RST_FSSPD  = 10'h000;
  localparam logic [7:0]  RST_HOLD   = 8'h00;
  localparam logic [7:0]  RST_AMP    = 8'h29;
  localparam logic [13:0] RST_INTSPD = 14'h0408;
  localparam logic [7:0]  RST_STSLP  = 8'h19;
  localparam logic [7:0]  RST_FNSLP  = 8'h29;
  localparam logic [3:0]  RST_THERM  = 4'h0;
  localparam logic [3:0]  RST_OCD    = 4'h8;
  localparam logic [6:0]  RST_STALL  = 7'h40;
  localparam logic [7:0]  RST_STEP   = 8'h07;

  localparam logic [9:0]  FSSPD_NEVER = 10'h3ff;

  // Timing: one speed tick is 250 ns
  localparam int CLK_PERIOD_PS = 25000;
  localparam int TICK_NS       = 250;
  localparam int TICK_CYCLES   =
    (TICK_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [3:0] TICK_LAST = 4'(TICK_CYCLES - 1);

  // Coefficient encodings
  localparam logic [5:0]  THERM_ONE    = 6'h20;
  localparam logic [4:0]  ADC_LOW_SAT  = 5'h08;
  localparam logic [4:0]  ADC_HIGH_SAT = 5'h18;
  localparam logic [10:0] SUP_COEF_MAX = 11'h7e0;
  localparam logic [10:0] SUP_COEF_MIN = 11'h2a0;
  localparam logic [14:0] SUP_NUMER    = 15'h4000;
  localparam logic [8:0]  OCD_STEP_MA  = 9'h177;
  localparam logic [6:0]  STALL_STEP_Q = 7'h7d;

  typedef enum logic [3:0] {
    MOT_STOPPED = 4'b0001,
    MOT_ACCEL   = 4'b0010,
    MOT_DECEL   = 4'b0100,
    MOT_CONST   = 4'b1000
  } sps_motion_t;

  typedef struct packed {
    logic [11:0] decel;
    logic [9:0]  max_speed;
    logic [12:0] min_speed;
    logic [9:0]  fs_speed;
    logic [7:0]  hold_amp;
    logic [7:0]  run_amp;
    logic [7:0]  acc_amp;
    logic [7:0]  dec_amp;
    logic [13:0] int_speed;
    logic [7:0]  start_slope;
    logic [7:0]  acc_slope;
    logic [7:0]  dec_slope;
    logic [3:0]  therm;
    logic [4:0]  adc;
    logic [3:0]  ocd;
    logic [6:0]  stall;
    logic [7:0]  step_mode;
    logic        notperf;
    logic        el_reset;
    logic [3:0]  tick_cnt;
    logic        tick;
    logic [21:0] rdata;
    logic        rvalid;
    logic        full_step;
    logic [7:0]  amp;
    logic [7:0]  slope;
    logic        comp_en;
    logic [15:0] drive;
  } sps_state_t;

  typedef struct packed {
    logic [5:0]  therm_coef;
    logic [10:0] supply_coef;
    logic [12:0] ocd_ma;
    logic [13:0] stall_qma;
  } sps_coef_t;

endpackage

// [sps_coef_if.sv]
// Codes and decoded coefficients between the register set and decoder
`timescale 1ns/1ps
`default_nettype none
interface sps_coef_if;
  logic [3:0]  therm_code;
  logic [4:0]  adc_code;
  logic [3:0]  ocd_code;
  logic [6:0]  stall_code;
  logic [5:0]  therm_coef;
  logic [10:0] supply_coef;
  logic [12:0] ocd_ma;
  logic [13:0] stall_qma;

  modport dec (input therm_code, adc_code, ocd_code, stall_code,
               output therm_coef, supply_coef, ocd_ma, stall_qma);
  modport regs (output therm_code, adc_code, ocd_code, stall_code,
                input therm_coef, supply_coef, ocd_ma, stall_qma);
endinterface
`default_nettype wire

// [sps_coef_decode.sv]
// Registered decode of thermal, supply, overcurrent and stall codes
`timescale 1ns/1ps
`default_nettype none
module sps_coef_decode (
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  sps_coef_if.dec   coef
);

  sps_pkg::sps_coef_t q;
  sps_pkg::sps_coef_t d;
  logic [14:0]        quot;

  always_comb begin
    d = q;
    quot = 15'h0000;
    d.therm_coef = sps_pkg::THERM_ONE + {2'b00, coef.therm_code}; // RULE13
    // Supply coefficient is 16/code, clamped to the end codes
    if (coef.adc_code <= sps_pkg::ADC_LOW_SAT) begin
      d.supply_coef = sps_pkg::SUP_COEF_MAX; // RULE16
    end else if (coef.adc_code >= sps_pkg::ADC_HIGH_SAT) begin
      d.supply_coef = sps_pkg::SUP_COEF_MIN; // RULE16
    end else begin
      quot = sps_pkg::SUP_NUMER / {10'h000, coef.adc_code};
      d.supply_coef = quot[10:0]; // RULE16
    end
    d.ocd_ma = 13'({4'h0, sps_pkg::OCD_STEP_MA} *
                   ({9'h000, coef.ocd_code} + 13'h0001)); // RULE17
    d.stall_qma = 14'({7'h00, sps_pkg::STALL_STEP_Q} *
                      ({7'h00, coef.stall_code} + 14'h0001)); // RULE18
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign coef.therm_coef  = q.therm_coef;
  assign coef.supply_coef = q.supply_coef;
  assign coef.ocd_ma      = q.ocd_ma;
  assign coef.stall_qma   = q.stall_qma;

endmodule // sps_coef_decode
`default_nettype wire

// [sps_param_set.sv]
// Motion parameter register set with run-time write lock and decodes
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RULE1: Holds deceleration as unsigned 0.40 steps per tick squared, tick 250 ns.
// RULE2: While running, writes to decel, intersect or slopes dropped, flag set.
// RULE3: Holds maximum speed as unsigned 0.18 steps per tick.
// RULE4: Minimum speed register: bit 12 optimisation enable, bits 11..0 speed.
// RULE5: Optimisation on: field is compensation threshold, profile minimum zero.
// RULE6: Minimum speed write while running sets the not-performed flag.
// RULE7: Above full-step threshold (value plus half) drive switches to full step.
// RULE8: Threshold 3ff keeps microstepping; zero still means a small threshold.
// RULE9: Amplitude picked by motion state; output is supply times code over 256.
// RULE10: Compensation slope changes at intersect speed, scale 2^-26.
// RULE11: Start slope below intersect; final accel or decel slope above it.
// RULE12: All three slopes zero disables back-EMF compensation.
// RULE13: Thermal coefficient is one plus code times 1/32.
// RULE14: Supply conversion result is always readable.
// RULE15: Writes to conversion result are dropped and set the flag.
// RULE16: Supply coefficient one at code 16, clamped at codes 8 and 24.
// RULE17: Overcurrent threshold is code plus one times 375 mA.
// RULE18: Stall threshold is code plus one times 31.25 mA.
// RULE19: Step mode: sync enable bit 7, source 6..4, step select 2..0.
// RULE20: Step select codes full, half, then 1/4 to 1/128 microstep.
// RULE21: Changing step select (bits 2..0) resets electrical position to first microstep.
// RULE22: Step mode write while running is dropped and sets the flag.
// RULE23: Not-performed flag is sticky and exported to status logic.
module sps_param_set (
  input  wire logic                 i_clk,
  input  wire logic                 i_reset_n,
  input  wire logic                 i_wr_en,
  input  wire logic                 i_rd_en,
  input  wire logic [5:0]           i_addr,
  input  wire logic [21:0]          i_wdata,
  output logic      [21:0]          o_rdata,
  output logic                      o_rdata_valid,
  input  wire logic                 i_motor_running,
  input  wire sps_pkg::sps_motion_t i_motion_state,
  input  wire logic [19:0]          i_actual_speed,
  input  wire logic [15:0]          i_supply_level,
  input  wire logic [4:0]           i_supply_sense_input,
  input  wire logic                 i_notperf_clear,
  output logic                      o_command_not_performed_flag,
  output logic                      o_tick,
  output logic      [11:0]          o_decel_rate,
  output logic      [9:0]           o_max_speed,
  output logic      [11:0]          o_profile_min_speed,
  output logic      [11:0]          o_comp_threshold_speed,
  output logic                      o_low_speed_opt_enable,
  output logic                      o_full_step_active,
  output logic      [7:0]           o_amplitude,
  output logic      [15:0]          o_drive_level,
  output logic      [7:0]           o_bemf_slope,
  output logic                      o_bemf_comp_enable,
  output logic                      o_sync_enable,
  output logic      [2:0]           o_sync_select,
  output logic      [7:0]           o_microsteps_per_step,
  output logic                      o_el_pos_reset,
  output logic      [5:0]           o_thermal_coef,
  output logic      [10:0]          o_supply_coef,
  output logic      [12:0]          o_ocd_threshold_ma,
  output logic      [13:0]          o_stall_threshold_qma
);

  sps_pkg::sps_state_t q;
  sps_pkg::sps_state_t d;
  sps_coef_if          coef ();

  logic [19:0] fs_thr;
  logic [19:0] int_thr;
  logic        above_int;
  logic        set_flag;
  logic [21:0] rd_mux;
  logic [23:0] product;

  sps_coef_decode u_coef (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .coef      (coef)
  );

  assign coef.therm_code = q.therm;
  assign coef.adc_code   = q.adc;
  assign coef.ocd_code   = q.ocd;
  assign coef.stall_code = q.stall;

  // Speeds compared in 2^-28 step/tick units of the actual speed
  assign fs_thr  = {q.fs_speed, 1'b1, 9'h000}; // RULE7
  assign int_thr = {4'h0, q.int_speed, 2'b00}; // RULE10
  assign above_int = i_actual_speed > int_thr; // RULE10
  assign product = i_supply_level * q.amp;

  always_comb begin
    rd_mux = 22'h000000;
    case (i_addr)
      sps_pkg::ADDR_DECEL:  rd_mux = {10'h000, q.decel};
      sps_pkg::ADDR_MAXSPD: rd_mux = {12'h000, q.max_speed};
      sps_pkg::ADDR_MINSPD: rd_mux = {9'h000, q.min_speed};
      sps_pkg::ADDR_HOLD:   rd_mux = {14'h0000, q.hold_amp};
      sps_pkg::ADDR_RUN:    rd_mux = {14'h0000, q.run_amp};
      sps_pkg::ADDR_ACCAMP: rd_mux = {14'h0000, q.acc_amp};
      sps_pkg::ADDR_DECAMP: rd_mux = {14'h0000, q.dec_amp};
      sps_pkg::ADDR_INTSPD: rd_mux = {8'h00, q.int_speed};
      sps_pkg::ADDR_STSLP:  rd_mux = {14'h0000, q.start_slope};
      sps_pkg::ADDR_FNACC:  rd_mux = {14'h0000, q.acc_slope};
      sps_pkg::ADDR_FNDEC:  rd_mux = {14'h0000, q.dec_slope};
      sps_pkg::ADDR_THERM:  rd_mux = {18'h00000, q.therm};
      sps_pkg::ADDR_ADC:    rd_mux = {17'h00000, q.adc}; // RULE14
      sps_pkg::ADDR_OCD:    rd_mux = {18'h00000, q.ocd};
      sps_pkg::ADDR_STALL:  rd_mux = {15'h0000, q.stall};
      sps_pkg::ADDR_FSSPD:  rd_mux = {12'h000, q.fs_speed};
      sps_pkg::ADDR_STEP:   rd_mux = {14'h0000, q.step_mode};
      default:              rd_mux = 22'h000000;
    endcase
  end

  always_comb begin
    d = q;
    set_flag   = 1'b0;
    d.el_reset = 1'b0;
    d.rvalid   = 1'b0;
    d.tick     = 1'b0;

    // 250 ns speed tick from the 40 MHz clock
    if (q.tick_cnt == sps_pkg::TICK_LAST) begin
      d.tick_cnt = 4'h0;
      d.tick     = 1'b1;
    end else begin
      d.tick_cnt = q.tick_cnt + 4'h1;
    end

    d.adc = i_supply_sense_input; // RULE14

    if (i_wr_en) begin
      case (i_addr)
        sps_pkg::ADDR_DECEL: begin
          if (i_motor_running) set_flag = 1'b1; // RULE2
          else d.decel = i_wdata[11:0]; // RULE1
        end
        sps_pkg::ADDR_MAXSPD: d.max_speed = i_wdata[9:0]; // RULE3
        sps_pkg::ADDR_MINSPD: begin
          // Dropped as well as flagged, so a running profile never shifts
          if (i_motor_running) set_flag = 1'b1; // RULE6
          else d.min_speed = i_wdata[12:0]; // RULE4
        end
        sps_pkg::ADDR_HOLD:   d.hold_amp = i_wdata[7:0];
        sps_pkg::ADDR_RUN:    d.run_amp  = i_wdata[7:0];
        sps_pkg::ADDR_ACCAMP: d.acc_amp  = i_wdata[7:0];
        sps_pkg::ADDR_DECAMP: d.dec_amp  = i_wdata[7:0];
        sps_pkg::ADDR_INTSPD: begin
          if (i_motor_running) set_flag = 1'b1; // RULE2
          else d.int_speed = i_wdata[13:0];
        end
        sps_pkg::ADDR_STSLP: begin
          if (i_motor_running) set_flag = 1'b1; // RULE2
          else d.start_slope = i_wdata[7:0];
        end
        sps_pkg::ADDR_FNACC: begin
          if (i_motor_running) set_flag = 1'b1; // RULE2
          else d.acc_slope = i_wdata[7:0];
        end
        sps_pkg::ADDR_FNDEC: begin
          if (i_motor_running) set_flag = 1'b1; // RULE2
          else d.dec_slope = i_wdata[7:0];
        end
        sps_pkg::ADDR_THERM:  d.therm    = i_wdata[3:0];
        sps_pkg::ADDR_ADC:    set_flag   = 1'b1; // RULE15
        sps_pkg::ADDR_OCD:    d.ocd      = i_wdata[3:0];
        sps_pkg::ADDR_STALL:  d.stall    = i_wdata[6:0];
        sps_pkg::ADDR_FSSPD:  d.fs_speed = i_wdata[9:0];
        sps_pkg::ADDR_STEP: begin
          if (i_motor_running) begin
            set_flag = 1'b1; // RULE22
          end else begin
            // Bit 3 is forced to zero whatever the host writes
            d.step_mode = {i_wdata[7:4], 1'b0, i_wdata[2:0]}; // RULE19
            d.el_reset  = i_wdata[2:0] != q.step_mode[2:0]; // RULE21
          end
        end
        default: ;
      endcase
    end

    // Set wins over clear so no refused write goes unreported
    if (i_notperf_clear) d.notperf = 1'b0;
    if (set_flag) d.notperf = 1'b1; // RULE23

    if (i_rd_en) begin
      d.rvalid = 1'b1;
      d.rdata  = rd_mux;
    end

    d.full_step = (q.fs_speed != sps_pkg::FSSPD_NEVER) &&
                  (i_actual_speed > fs_thr); // RULE8

    unique case (i_motion_state)
      sps_pkg::MOT_STOPPED: d.amp = q.hold_amp; // RULE9
      sps_pkg::MOT_ACCEL:   d.amp = q.acc_amp; // RULE9
      sps_pkg::MOT_DECEL:   d.amp = q.dec_amp; // RULE9
      sps_pkg::MOT_CONST:   d.amp = q.run_amp; // RULE9
      default:              d.amp = q.hold_amp;
    endcase
    d.drive = product[23:8]; // RULE9

    // Constant speed above intersect keeps the acceleration slope
    if (!above_int) begin
      d.slope = q.start_slope; // RULE11
    end else if (i_motion_state == sps_pkg::MOT_DECEL) begin
      d.slope = q.dec_slope; // RULE11
    end else begin
      d.slope = q.acc_slope; // RULE11
    end
    d.comp_en = (q.start_slope != 8'h00) || (q.acc_slope != 8'h00) ||
                (q.dec_slope != 8'h00); // RULE12
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      q <= '0;
      q.decel       <= sps_pkg::RST_DECEL;
      q.max_speed   <= sps_pkg::RST_MAXSPD;
      q.min_speed   <= sps_pkg::RST_MINSPD;
      q.fs_speed    <= sps_pkg::RST_FSSPD;
      q.hold_amp    <= sps_pkg::RST_HOLD;
      q.run_amp     <= sps_pkg::RST_AMP;
      q.acc_amp     <= sps_pkg::RST_AMP;
      q.dec_amp     <= sps_pkg::RST_AMP;
      q.int_speed   <= sps_pkg::RST_INTSPD;
      q.start_slope <= sps_pkg::RST_STSLP;
      q.acc_slope   <= sps_pkg::RST_FNSLP;
      q.dec_slope   <= sps_pkg::RST_FNSLP;
      q.therm       <= sps_pkg::RST_THERM;
      q.ocd         <= sps_pkg::RST_OCD;
      q.stall       <= sps_pkg::RST_STALL;
      q.step_mode   <= sps_pkg::RST_STEP;
    end else begin
      q <= d;
    end
  end

  assign o_rdata                      = q.rdata;
  assign o_rdata_valid                = q.rvalid;
  assign o_command_not_performed_flag = q.notperf; // RULE23
  assign o_tick                       = q.tick;
  assign o_decel_rate                 = q.decel; // RULE1
  assign o_max_speed                  = q.max_speed; // RULE3
  assign o_low_speed_opt_enable       = q.min_speed[sps_pkg::MINSPD_LSPD_BIT];
  assign o_profile_min_speed = o_low_speed_opt_enable ? 12'h000 :
                               q.min_speed[11:0]; // RULE5
  assign o_comp_threshold_speed = o_low_speed_opt_enable ?
                                  q.min_speed[11:0] : 12'h000; // RULE5
  assign o_full_step_active     = q.full_step;
  assign o_amplitude            = q.amp;
  assign o_drive_level          = q.drive;
  assign o_bemf_slope           = q.comp_en ? q.slope : 8'h00; // RULE12
  assign o_bemf_comp_enable     = q.comp_en;
  assign o_sync_enable          = q.step_mode[sps_pkg::STEP_SYNC_EN];
  assign o_sync_select = q.step_mode[sps_pkg::STEP_SYNC_LSB +: 3]; // RULE19
  assign o_microsteps_per_step  = 8'h01 << q.step_mode[2:0]; // RULE20
  assign o_el_pos_reset         = q.el_reset;
  assign o_thermal_coef         = coef.therm_coef;
  assign o_supply_coef          = coef.supply_coef;
  assign o_ocd_threshold_ma     = coef.ocd_ma;
  assign o_stall_threshold_qma  = coef.stall_qma;

endmodule // sps_param_set
`default_nettype wire

// [sps_dummy_unused_never.sv]
// Spare source file, holds no code

// [sps_param_set_props.sv]
// Checker for the parameter set command port and derived outputs
`timescale 1ns/1ps
`default_nettype none
module sps_param_set_props (
  input wire logic        i_clk,
  input wire logic        i_reset_n,
  input wire logic        i_wr_en,
  input wire logic        i_rd_en,
  input wire logic [5:0]  i_addr,
  input wire logic        i_motor_running,
  input wire logic [19:0] i_actual_speed,
  input wire logic        i_notperf_clear,
  input wire logic        o_rdata_valid,
  input wire logic        o_command_not_performed_flag,
  input wire logic        o_tick,
  input wire logic [11:0] o_profile_min_speed,
  input wire logic [11:0] o_comp_threshold_speed,
  input wire logic        o_low_speed_opt_enable,
  input wire logic        o_full_step_active,
  input wire logic [7:0]  o_microsteps_per_step,
  input wire logic        o_el_pos_reset
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  sequence s_step_wr;
    i_wr_en && i_addr == 6'h16 && !i_motor_running;
  endsequence
  sequence s_locked_wr;
    i_wr_en && i_motor_running &&
      i_addr inside {6'h05, 6'h08, 6'h0d, 6'h0e, 6'h0f, 6'h10, 6'h16};
  endsequence
  property p_rd_answer;
    i_rd_en |=> o_rdata_valid;
  endproperty
  property p_lock;
    s_locked_wr |=> o_command_not_performed_flag;
  endproperty
  property p_adc_wr;
    i_wr_en && i_addr == 6'h12 |=> o_command_not_performed_flag;
  endproperty
  property p_sticky;
    o_command_not_performed_flag && !i_notperf_clear
      |=> o_command_not_performed_flag;
  endproperty
  property p_lspd;
    (o_low_speed_opt_enable ? o_profile_min_speed
                            : o_comp_threshold_speed) == 12'h000;
  endproperty
  // Threshold never drops below half a unit
  property p_fs_low;
    i_actual_speed <= 20'h00200 |=> !o_full_step_active;
  endproperty
  property p_el_reset;
    s_step_wr ##1 (o_microsteps_per_step != $past(o_microsteps_per_step))
      |-> o_el_pos_reset;
  endproperty
  property p_step_lock;
    i_wr_en && i_addr == 6'h16 && i_motor_running
      |=> $stable(o_microsteps_per_step) && !o_el_pos_reset;
  endproperty
  property p_tick;
    o_tick |=> !o_tick [*8] ##1 !o_tick ##1 o_tick;
  endproperty
  a_rd_answer:
    assert property (p_rd_answer) else $error("read not answered");
  a_lock:
    assert property (p_lock) else $error("locked write not flagged");
  a_adc_wr:
    assert property (p_adc_wr) else $error("result write not flagged");
  a_sticky:
    assert property (p_sticky) else $error("flag dropped uncleared");
  a_lspd:
    assert property (p_lspd) else $error("min speed split wrong");
  a_fs_low:
    assert property (p_fs_low) else $error("full step too early");
  a_el_reset:
    assert property (p_el_reset) else $error("no position reset");
  a_step_lock:
    assert property (p_step_lock) else $error("step mode changed running");
  a_tick:
    assert property (p_tick) else $error("tick period wrong");
endmodule // sps_param_set_props

bind sps_param_set sps_param_set_props u_props (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_wr_en(i_wr_en),
  .i_rd_en(i_rd_en), .i_addr(i_addr), .i_motor_running(i_motor_running),
  .i_actual_speed(i_actual_speed), .i_notperf_clear(i_notperf_clear),
  .o_rdata_valid(o_rdata_valid), .o_tick(o_tick),
  .o_command_not_performed_flag(o_command_not_performed_flag),
  .o_profile_min_speed(o_profile_min_speed),
  .o_comp_threshold_speed(o_comp_threshold_speed),
  .o_low_speed_opt_enable(o_low_speed_opt_enable),
  .o_full_step_active(o_full_step_active),
  .o_microsteps_per_step(o_microsteps_per_step),
  .o_el_pos_reset(o_el_pos_reset));
`default_nettype wire

// [sps_host_model.sv]
// Host model issuing register commands on the command port
`timescale 1ns/1ps
`default_nettype none
module sps_host_model (
  input  wire logic        i_clk,
  output logic             o_wr_en,
  output logic             o_rd_en,
  output logic [5:0]       o_addr,
  output logic [21:0]      o_wdata,
  input  wire logic [21:0] i_rdata,
  input  wire logic        i_rdata_valid
);
  initial {o_wr_en, o_rd_en, o_addr, o_wdata} = '0;
  task automatic wr(input logic [5:0] a, input logic [21:0] d);
    @(posedge i_clk);
    o_wr_en <= 1'b1;
    o_addr  <= a;
    o_wdata <= (a == sps_pkg::ADDR_STEP) ? (d & 22'h3ffff7) : d;
    @(posedge i_clk);
    o_wr_en <= 1'b0;
    o_wdata <= ~d;
  endtask
  // Answer is taken at the edge where valid is sampled high
  task automatic rd(input logic [5:0] a, output logic v,
                    output logic [21:0] q);
    @(posedge i_clk);
    o_rd_en <= 1'b1;
    o_addr  <= a;
    @(posedge i_clk);
    o_rd_en <= 1'b0;
    @(posedge i_clk);
    v = i_rdata_valid;
    q = i_rdata;
  endtask
endmodule // sps_host_model
`default_nettype wire

// [sps_param_set_bench.sv]
// Self-checking bench for the motion parameter register set
`timescale 1ns/1ps
`default_nettype none
module sps_param_set_bench;
  typedef struct packed {
    logic [5:0]  addr;
    logic [21:0] rst;
    logic [21:0] wd;
    logic [21:0] ex;
  } sps_row_t;
  logic        i_clk, i_reset_n, wr_en, rd_en, run, clr, flag, v;
  logic        lspd, fsa, cen, sen, elr, rvalid;
  logic [2:0]  ssel;
  logic [4:0]  sense;
  logic [5:0]  addr, therm;
  logic [7:0]  amp, slope, micro;
  logic [10:0] sup;
  logic [9:0]  mxs;
  logic [11:0] prof, cthr, dra;
  logic [12:0] ocd;
  logic [13:0] stall;
  logic [15:0] supply, drv;
  logic [19:0] speed;
  logic [21:0] wdata, rdata, q;
  int          mismatches, compares;
  sps_pkg::sps_motion_t mst;
  logic [7:0]  ea [4] = '{8'h11, 8'h33, 8'h44, 8'h22};
  logic [7:0]  es [4] = '{8'h20, 8'h20, 8'h30, 8'h20};
  logic [4:0]  sc [5] = '{5'h00, 5'h08, 5'h10, 5'h18, 5'h1f};
  logic [10:0] se [5] = '{11'h7e0, 11'h7e0, 11'h400, 11'h2a0, 11'h2a0};
  sps_row_t rows [18] = '{
    '{6'h05, 22'h0, 22'h3fffff, 22'hfff}, '{6'h07, 22'h0, 22'h2aa, 22'h2aa},
    '{6'h08, 22'h0, 22'h1234, 22'h1234}, '{6'h09, 22'h0, 22'ha5, 22'ha5},
    '{6'h0a, 22'h29, 22'hff, 22'hff}, '{6'h0b, 22'h29, 22'h01, 22'h01},
    '{6'h0c, 22'h29, 22'h80, 22'h80}, '{6'h0d, 22'h408, 22'h3fff, 22'h3fff},
    '{6'h0e, 22'h19, 22'h00, 22'h00}, '{6'h0f, 22'h29, 22'h7f, 22'h7f},
    '{6'h10, 22'h29, 22'hc3, 22'hc3}, '{6'h11, 22'h0, 22'h3fffff, 22'hf},
    '{6'h12, 22'h0, 22'h1f, 22'h0}, '{6'h13, 22'h8, 22'h5, 22'h5},
    '{6'h14, 22'h40, 22'h7f, 22'h7f}, '{6'h15, 22'h0, 22'h3ff, 22'h3ff},
    '{6'h16, 22'h07, 22'hfb, 22'hf3}, '{6'h3f, 22'h0, 22'habc, 22'h0}};

  sps_param_set dut (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_wr_en(wr_en), .i_rd_en(rd_en),
    .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata), .o_rdata_valid(rvalid),
    .i_motor_running(run), .i_motion_state(mst), .i_actual_speed(speed),
    .i_supply_level(supply), .i_supply_sense_input(sense),
    .i_notperf_clear(clr), .o_command_not_performed_flag(flag),
    .o_tick(), .o_decel_rate(dra), .o_max_speed(mxs),
    .o_profile_min_speed(prof), .o_comp_threshold_speed(cthr),
    .o_low_speed_opt_enable(lspd), .o_full_step_active(fsa),
    .o_amplitude(amp), .o_drive_level(drv), .o_bemf_slope(slope),
    .o_bemf_comp_enable(cen), .o_sync_enable(sen), .o_sync_select(ssel),
    .o_microsteps_per_step(micro), .o_el_pos_reset(elr),
    .o_thermal_coef(therm), .o_supply_coef(sup),
    .o_ocd_threshold_ma(ocd), .o_stall_threshold_qma(stall));
  sps_host_model host (.i_clk(i_clk), .o_wr_en(wr_en), .o_rd_en(rd_en),
    .o_addr(addr), .o_wdata(wdata), .i_rdata(rdata), .i_rdata_valid(rvalid));

  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  task automatic ck(input logic [21:0] g, input logic [21:0] e);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t value %h expected %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic rdck(input logic [5:0] a, input logic [21:0] e);
    host.rd(a, v, q);
    ck(22'(v), 22'h1);
    ck(q, e);
  endtask
  task automatic clear_flag();
    @(posedge i_clk);
    clr <= 1'b1;
    @(posedge i_clk);
    clr <= 1'b0;
  endtask
  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // A hang still reaches the verdict
  initial begin
    #(25 * 20000);
    mismatches++;
    test_done();
  end
  initial begin
    {i_reset_n, run, clr, speed, sense} = '0;
    mst = sps_pkg::MOT_STOPPED;
    supply = 16'h1000;
    cyc(10);
    i_reset_n <= 1'b1;
    foreach (rows[i]) begin
      rdck(rows[i].addr, rows[i].rst);
      host.wr(rows[i].addr, rows[i].wd);
      rdck(rows[i].addr, rows[i].ex);
      ck(22'(flag), 22'(rows[i].addr == 6'h12));
      clear_flag();
    end
    ck(22'({dra, mxs}), 22'h3ffeaa);
    $display("register table done");
    run <= 1'b1;
    foreach (rows[i]) if (rows[i].addr inside {6'h05, 6'h08, 6'h0d, 6'h0e,
                                             6'h0f, 6'h10, 6'h16}) begin
      host.wr(rows[i].addr, 22'h0);
      rdck(rows[i].addr, rows[i].ex);
      ck(22'(flag), 22'h1);
      clear_flag();
    end
    host.wr(6'h09, 22'h3c);
    rdck(6'h09, 22'h3c);
    ck(22'(flag), 22'h0);
    fork
      host.wr(6'h12, 22'h0);
      clear_flag();
    join
    cyc(3);
    ck(22'(flag), 22'h1);
    clear_flag();
    cyc(1);
    ck(22'(flag), 22'h0);
    run <= 1'b0;
    $display("write lock done");
    for (int s = 0; s < 8; s++) begin
      host.wr(6'h16, 22'h80 | 22'(s * 17));
      #1;
      ck(22'(elr), 22'h1);
      ck(22'(micro), 22'(1 << s));
      ck(22'({sen, ssel}), 22'(8 + s));
      cyc(1);
      #1;
      ck(22'(elr), 22'h0);
    end
    host.wr(6'h16, 22'h87);
    #1;
    ck(22'(elr), 22'h0);
    host.wr(6'h08, 22'h1abc);
    #1;
    ck(22'({lspd, prof}), 22'h1000);
    ck(22'(cthr), 22'habc);
    host.wr(6'h08, 22'h0abc);
    #1;
    ck(22'({lspd, prof}), 22'h0abc);
    ck(22'(cthr), 22'h0);
    host.wr(6'h15, 22'h0);
    speed <= 20'h00200;
    cyc(3);
    ck(22'(fsa), 22'h0);
    speed <= 20'h00201;
    cyc(3);
    ck(22'(fsa), 22'h1);
    host.wr(6'h15, 22'h3ff);
    speed <= 20'hfffff;
    cyc(3);
    ck(22'(fsa), 22'h0);
    $display("step and speed done");
    for (int k = 0; k < 4; k++) host.wr(6'(9 + k), 22'(17 * (k + 1)));
    for (int k = 0; k < 3; k++) host.wr(6'(14 + k), 22'(16 * (k + 1)));
    host.wr(6'h0d, 22'h1);
    for (int k = 0; k < 4; k++) begin
      mst <= sps_pkg::sps_motion_t'(4'h1 << k);
      cyc(4);
      ck(22'(amp), 22'(ea[k]));
      ck(22'(drv), 22'({ea[k], 4'h0}));
      ck(22'(slope), 22'(es[k]));
    end
    mst <= sps_pkg::MOT_ACCEL;
    speed <= 20'h0;
    cyc(4);
    ck(22'(slope), 22'h10);
    for (int k = 0; k < 3; k++) host.wr(6'(14 + k), 22'h0);
    cyc(4);
    ck(22'({cen, slope}), 22'h0);
    $display("amplitude and slope done");
    for (int n = 0; n < 128; n++) begin
      host.wr(6'h11, 22'(n));
      host.wr(6'h13, 22'(n));
      host.wr(6'h14, 22'(n));
      cyc(3);
      ck(22'(therm), 22'(32 + n % 16));
      ck(22'(ocd), 22'((n % 16 + 1) * 375));
      ck(22'(stall), 22'((n + 1) * 125));
    end
    foreach (sc[i]) begin
      sense <= sc[i];
      cyc(4);
      ck(22'(sup), 22'(se[i]));
      rdck(6'h12, 22'(sc[i]));
    end
    i_reset_n <= 1'b0;
    cyc(2);
    i_reset_n <= 1'b1;
    ck(22'({flag, micro}), 22'h80);
    rdck(6'h05, 22'h0);
    $display("coefficients done");
    test_done();
  end
endmodule // sps_param_set_bench
`default_nettype wire
